// ---- design/iwc_pkg.sv ----
// Shared constants of the idle wake-up controller: register map, fields,
// reset values, clock-enable indices and the controller state type.
// Assumes a 32-bit AHB-Lite register bus with word-aligned registers.
package iwc_pkg;

  // Register byte offsets.
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_MODE   = 8'h04;
  localparam logic [7:0] OFS_CLKSRC = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0c;

  // Power-save control fields.
  localparam int CTRL_STANDBY_REQ = 0;
  localparam int CTRL_PIN_NMI_MSK = 1;
  localparam int CTRL_WDT_NMI_MSK = 2;
  localparam int CTRL_MASKABLE_MSK = 3;
  localparam int CTRL_W = 4;
  localparam logic [3:0] CTRL_RST = 4'h0;

  // Power-save mode field.
  localparam int MODE_STANDBY_SEL = 0;
  localparam logic MODE_RST = 1'b0;

  // Clock-source selections of the peripherals that may run while idle.
  localparam int SRC_SECOND_16BIT_TIMER_WATCH   = 0;
  localparam int SRC_WATCH_MAIN   = 1;
  localparam int SRC_BYTE_PIN     = 2;  // Two bits, one per byte timer.
  localparam int SRC_BYTE_CMP     = 4;  // Two bits, one per byte timer.
  localparam int SRC_INTV_DIV2048 = 6;
  localparam int SRC_WDT2_DIV8    = 7;
  localparam int SRC_CSI_EXT      = 8;  // Two bits, one per serial port.
  localparam int SRC_ASYNC_PIN    = 10;
  localparam int SRC_SUBCLK_USED  = 11;
  localparam int SRC_W = 12;
  localparam logic [11:0] SRC_RST = 12'h000;

  // Status fields.
  localparam int STS_IDLE     = 0;
  localparam int STS_BY_NMI   = 1;
  localparam int STS_BY_MASK  = 2;
  localparam int STS_ACKED    = 3;
  localparam int STS_BRANCHED = 4;
  localparam int STS_NEXT     = 5;
  localparam int STS_W = 6;
  localparam logic [5:0] STS_RST = 6'h00;

  // Clock-enable vector indices.
  localparam int EN_CPU = 0;
  localparam int EN_INTC = 1;
  localparam int EN_FIRST_16BIT_TIMER = 2;
  localparam int EN_SECOND_16BIT_TIMER = 3;
  localparam int EN_BYTE0 = 4;   // Byte timers at 4 and 5.
  localparam int EN_INTV0 = 6;
  localparam int EN_INTV1 = 7;
  localparam int EN_WATCH = 8;
  localparam int EN_WDT1 = 9;
  localparam int EN_WDT2 = 10;
  localparam int EN_CSI0 = 11;   // Clocked serial ports at 11 and 12.
  localparam int EN_ASYNC0 = 13;
  localparam int EN_CSIA = 14;
  localparam int EN_TWI = 15;
  localparam int EN_OTHER = 16;  // All other main-clock peripherals.
  localparam int EN_W = 17;

  localparam int PRIO_W = 3;

  typedef enum logic [2:0] {
    ST_NORMAL = 3'b001,
    ST_IDLE   = 3'b010,
    ST_WAKE   = 3'b100
  } iwc_state_t;

endpackage

// ---- design/iwc_clk_if.sv ----
// Carrier between the controller and its clock-gate module.
// Assumes both ends run on the same core clock.
`timescale 1ns/1ns
interface iwc_clk_if;
  import iwc_pkg::*;
  logic              idle;
  logic [SRC_W-1:0]  src_cfg;
  logic [EN_W-1:0]   clk_en;
  modport ctrl (output idle, output src_cfg, input clk_en);
  modport gate (input idle, input src_cfg, output clk_en);
endinterface

// ---- design/iwc_clk_gate.sv ----
// Clock-enable decision for every unit while the device is idle.
// Assumes its idle and source settings come from registers of the caller.
`timescale 1ns/1ns
module iwc_clk_gate
  import iwc_pkg::*;
(
  // Control side.
  iwc_clk_if.gate cg
);

  logic sub;
  logic second_16bit_timer_run;
  logic watch_run;

  // Outside idle everything runs; inside idle only qualified units run.
  assign sub = cg.src_cfg[SRC_SUBCLK_USED];
  assign watch_run = sub | cg.src_cfg[SRC_WATCH_MAIN];
  assign second_16bit_timer_run = cg.src_cfg[SRC_SECOND_16BIT_TIMER_WATCH] & watch_run;

  // Fixed units: stopped in idle, or conditioned on their clock source.
  assign cg.clk_en[EN_CPU]   = ~cg.idle;
  assign cg.clk_en[EN_INTC]  = ~cg.idle;
  assign cg.clk_en[EN_FIRST_16BIT_TIMER]  = ~cg.idle;
  assign cg.clk_en[EN_SECOND_16BIT_TIMER]  = ~cg.idle | second_16bit_timer_run;
  assign cg.clk_en[EN_INTV0] = ~cg.idle;
  assign cg.clk_en[EN_INTV1] = ~cg.idle |
                               cg.src_cfg[SRC_INTV_DIV2048];
  assign cg.clk_en[EN_WATCH] = ~cg.idle | watch_run;
  assign cg.clk_en[EN_WDT1]  = ~cg.idle;
  assign cg.clk_en[EN_WDT2]  = ~cg.idle | sub |
                               cg.src_cfg[SRC_WDT2_DIV8];
  assign cg.clk_en[EN_ASYNC0] = ~cg.idle |
                                cg.src_cfg[SRC_ASYNC_PIN];
  assign cg.clk_en[EN_CSIA]  = ~cg.idle;
  assign cg.clk_en[EN_TWI]   = ~cg.idle;
  assign cg.clk_en[EN_OTHER] = ~cg.idle;

  // Paired units: byte timers and clocked serial ports.
  // A byte timer on the compare source only runs if its source timer runs.
  genvar m;
  generate
    for (m = 0; m < 2; m = m + 1) begin : g_pair
      assign cg.clk_en[EN_BYTE0+m] = ~cg.idle |
        cg.src_cfg[SRC_BYTE_PIN+m] |
        (cg.src_cfg[SRC_BYTE_CMP+m] & second_16bit_timer_run);
      assign cg.clk_en[EN_CSI0+m] = ~cg.idle |
        cg.src_cfg[SRC_CSI_EXT+m];
    end
  endgenerate

endmodule

// ---- design/iwc_top.sv ----
// Idle-mode wake-up controller: register file, idle state machine, wake
// decision and reset forwarding.
// Assumes an AHB-Lite master, a CPU that reports its interrupt enable and
// the priority in service, and an interrupt controller that keeps pending
// requests until it acknowledges them.
//
// Notes on behaviour
// - Standby request written with select bit zero in normal mode enters idle.
// - In idle the main oscillator runs; CPU and main-clock units stop.
// - Wake on NMIs, unmasked requests, or any reset but first watchdog.
// - After release normal operation resumes at once, no stabilisation wait.
// - Any unmasked request ends idle, whatever its priority.
// - In a handler, a lower-priority request only wakes, no acknowledge.
// - Such an unacknowledged request stays pending in the controller.
// - Higher-priority request with interrupts on, or non-maskable one, wakes and is acknowledged.
// - Release by a non-maskable request branches to its handler.
// - Maskable release with interrupts on branches or continues by priority.
// - Maskable release with interrupts off continues at the next instruction.
// - A class with its wake mask bit at one is ignored in idle.
// - A reset that ends idle runs the ordinary reset sequence.
// - Second 16-bit timer runs in idle only on watch-timer interrupt source.
// - Byte timers run in idle only from pin or compare interrupt.
// - Second interval timer runs in idle only on divide-by-2048 source.
// - Watch timer runs in idle on main clock, or always with subclock.
// - Second watchdog runs on divide-by-8 or subclock; first one stops.
// - Clocked serial ports run in idle only on external shift clock.
// - First async port runs in idle only on external baud clock.
`timescale 1ns/1ns
module iwc_top
  import iwc_pkg::*;
(
  // Clock and reset.
  input  wire logic              core_clk,
  input  wire logic              reset,
  // AHB-Lite slave.
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic                   hreadyout,
  output logic                   hresp,
  output logic [31:0]            hrdata,
  // Wake sources.
  input  wire logic              nmi_pin,
  input  wire logic              wdt_nmi_req,
  input  wire logic              maskable_req,
  input  wire logic [PRIO_W-1:0] req_prio,
  // CPU state.
  input  wire logic              int_enable,
  input  wire logic              in_service,
  input  wire logic [PRIO_W-1:0] svc_prio,
  // Reset sources.
  input  wire logic              reset_pin,
  input  wire logic              internal_reset_req,
  input  wire logic              first_watchdog_reset,
  // Results.
  output logic [EN_W-1:0]        clk_en,
  output logic                   main_osc_en,
  output logic                   idle_active,
  output logic                   wake_ack,
  output logic                   resume_branch,
  output logic                   resume_next,
  output logic                   system_reset_req
);

  iwc_clk_if cif ();

  // Pin synchronisers: three stages, a change counts once 2 and 3 agree.
  logic [2:0] nmi_sync_reg;
  logic [2:0] nmi_sync_next;
  logic [2:0] rst_sync_reg;
  logic [2:0] rst_sync_next;
  logic       nmi_flt_reg;
  logic       nmi_flt_next;
  logic       rst_flt_reg;
  logic       rst_flt_next;

  always_comb begin
    nmi_sync_next = {nmi_sync_reg[1:0], nmi_pin};
    rst_sync_next = {rst_sync_reg[1:0], reset_pin};
    nmi_flt_next = nmi_flt_reg;
    rst_flt_next = rst_flt_reg;
    if (nmi_sync_reg[1] == nmi_sync_reg[2]) begin
      nmi_flt_next = nmi_sync_reg[2];
    end
    if (rst_sync_reg[1] == rst_sync_reg[2]) begin
      rst_flt_next = rst_sync_reg[2];
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      nmi_sync_reg <= 3'h0;
      rst_sync_reg <= 3'h0;
      nmi_flt_reg <= 1'b0;
      rst_flt_reg <= 1'b0;
    end else begin
      nmi_sync_reg <= nmi_sync_next;
      rst_sync_reg <= rst_sync_next;
      nmi_flt_reg <= nmi_flt_next;
      rst_flt_reg <= rst_flt_next;
    end
  end

  // Bus data-phase bookkeeping and register file.
  logic               wr_pend_reg;
  logic               wr_pend_next;
  logic [7:0]         wr_addr_reg;
  logic [7:0]         wr_addr_next;
  logic [CTRL_W-1:0]  power_save_ctrl_reg;
  logic [CTRL_W-1:0]  power_save_ctrl_next;
  logic               power_save_mode_reg;
  logic               power_save_mode_next;
  logic [SRC_W-1:0]   clk_src_reg;
  logic [SRC_W-1:0]   clk_src_next;
  logic [31:0]        rdata_reg;
  logic [31:0]        rdata_next;
  logic [STS_W-1:0]   status_reg;
  logic               addr_phase;
  logic               enter_req;
  iwc_state_t         state_reg;
  iwc_state_t         state_next;

  assign addr_phase = hsel & htrans[1] & hready;

  // Read data is sampled at the address phase so it stands for the whole
  // data phase; the price is that a read right behind a write to the same
  // register sees the old value.
  always_comb begin
    wr_pend_next = addr_phase & hwrite;
    wr_addr_next = addr_phase ? {haddr[7:2], 2'b00} : wr_addr_reg;
    power_save_ctrl_next = power_save_ctrl_reg;
    power_save_mode_next = power_save_mode_reg;
    clk_src_next = clk_src_reg;
    rdata_next = rdata_reg;
    enter_req = 1'b0;
    if (wr_pend_reg) begin
      case (wr_addr_reg)
        OFS_CTRL: begin
          power_save_ctrl_next = hwdata[CTRL_W-1:0];
          // Standby request is a strobe; the idle state holds its effect.
          power_save_ctrl_next[CTRL_STANDBY_REQ] = 1'b0;
          enter_req = hwdata[CTRL_STANDBY_REQ] &
                      ~power_save_mode_reg &
                      (state_reg == ST_NORMAL);
        end
        OFS_MODE: power_save_mode_next = hwdata[MODE_STANDBY_SEL];
        OFS_CLKSRC: clk_src_next = hwdata[SRC_W-1:0];
        default: ;
      endcase
    end
    if (addr_phase & ~hwrite) begin
      case ({haddr[7:2], 2'b00})
        OFS_CTRL: rdata_next = {28'h0000000, power_save_ctrl_reg};
        OFS_MODE: rdata_next = {31'h00000000, power_save_mode_reg};
        OFS_CLKSRC: rdata_next = {20'h00000, clk_src_reg};
        OFS_STATUS: rdata_next = {26'h0000000, status_reg};
        default: rdata_next = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      power_save_ctrl_reg <= CTRL_RST;
      power_save_mode_reg <= MODE_RST;
      clk_src_reg <= SRC_RST;
      rdata_reg <= 32'h00000000;
    end else begin
      wr_pend_reg <= wr_pend_next;
      wr_addr_reg <= wr_addr_next;
      power_save_ctrl_reg <= power_save_ctrl_next;
      power_save_mode_reg <= power_save_mode_next;
      clk_src_reg <= clk_src_next;
      rdata_reg <= rdata_next;
    end
  end

  // Zero-wait slave, always OKAY.
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_reg;

  // Wake decision. Masked classes count for nothing in idle.
  logic nmi_wake;
  logic mask_wake;
  logic higher;
  logic take_ack;

  always_comb begin
    nmi_wake = (nmi_flt_reg &
                ~power_save_ctrl_reg[CTRL_PIN_NMI_MSK]) |
               (wdt_nmi_req &
                ~power_save_ctrl_reg[CTRL_WDT_NMI_MSK]);
    mask_wake = maskable_req &
                ~power_save_ctrl_reg[CTRL_MASKABLE_MSK];
    // A smaller number is the higher priority.
    higher = ~in_service | (req_prio < svc_prio);
    // Non-maskable always taken; maskable only if enabled and higher.
    take_ack = nmi_wake | (mask_wake & int_enable & higher);
  end

  // Idle state machine and release results.
  logic               ack_reg;
  logic               ack_next;
  logic               branch_reg;
  logic               branch_next;
  logic               next_reg;
  logic               next_next;
  logic [STS_W-1:0]   status_next;
  logic               sysrst_reg;
  logic               sysrst_next;
  logic               rst_src;

  always_comb begin
    state_next = state_reg;
    ack_next = 1'b0;
    branch_next = 1'b0;
    next_next = 1'b0;
    status_next = status_reg;
    status_next[STS_IDLE] = 1'b0;
    // Any reset source but the first watchdog; that one is stopped in idle
    // and is honoured outside it like any other reset.
    rst_src = rst_flt_reg | internal_reset_req |
              (first_watchdog_reset & (state_reg != ST_IDLE));
    // The same reset request is raised in and out of idle.
    sysrst_next = rst_src;
    case (state_reg)
      ST_NORMAL: begin
        if (enter_req & ~rst_src) begin
          state_next = ST_IDLE;
        end
      end
      ST_IDLE: begin
        status_next[STS_IDLE] = 1'b1;
        if (rst_src) begin
          state_next = ST_NORMAL;
        end else if (nmi_wake | mask_wake) begin
          // Priority never blocks the wake itself.
          state_next = ST_WAKE;
          status_next[STS_BY_NMI] = nmi_wake;
          status_next[STS_BY_MASK] = ~nmi_wake;
          status_next[STS_ACKED] = take_ack;
          status_next[STS_BRANCHED] = take_ack;
          status_next[STS_NEXT] = ~take_ack;
          // Acknowledge only a request that wins; a losing one is left
          // pending in the interrupt controller untouched.
          ack_next = take_ack;
          // NMI or winning maskable branches to its handler.
          branch_next = take_ack;
          // Disabled or lower priority continues with the next instruction.
          next_next = ~take_ack;
        end
      end
      ST_WAKE: begin
        // Main oscillator never stopped, so release takes one cycle.
        state_next = ST_NORMAL;
      end
      default: state_next = ST_NORMAL;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_reg <= ST_NORMAL;
      ack_reg <= 1'b0;
      branch_reg <= 1'b0;
      next_reg <= 1'b0;
      status_reg <= STS_RST;
      sysrst_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      ack_reg <= ack_next;
      branch_reg <= branch_next;
      next_reg <= next_next;
      status_reg <= status_next;
      sysrst_reg <= sysrst_next;
    end
  end

  // Clock gating of the units that may keep running while idle.
  assign cif.idle = (state_reg == ST_IDLE);
  assign cif.src_cfg = clk_src_reg;

  iwc_clk_gate u_gate (
    .cg (cif.gate)
  );

  // Outputs. The main oscillator is never stopped by this block.
  assign clk_en = cif.clk_en;
  assign main_osc_en = 1'b1;
  assign idle_active = (state_reg == ST_IDLE);
  assign wake_ack = ack_reg;
  assign resume_branch = branch_reg;
  assign resume_next = next_reg;
  assign system_reset_req = sysrst_reg;

endmodule

// ---- tb/iwc_props.sv ----
// Concurrent checks on the idle wake-up controller's top-level ports.
// Assumes it is bound to iwc_top and sees only that module's ports.
`timescale 1ns/1ns
module iwc_props
  import iwc_pkg::*;
(
  // Clock and reset.
  input wire logic            core_clk,
  input wire logic            reset,
  // Reset sources.
  input wire logic            reset_pin,
  input wire logic            internal_reset_req,
  input wire logic            first_watchdog_reset,
  // Results.
  input wire logic [EN_W-1:0] clk_en,
  input wire logic            main_osc_en,
  input wire logic            idle_active,
  input wire logic            wake_ack,
  input wire logic            resume_branch,
  input wire logic            resume_next,
  input wire logic            system_reset_req
);
  // Units that never run while idle, whatever the clock setup.
  localparam logic [EN_W-1:0] STOP_MASK = 17'h1c247;
  logic [4:0] pin_hist_reg;
  logic [4:0] pin_hist_next;

  // The reset pin passes a synchroniser, so a quiet pin is trusted only
  // once it has been low for longer than that pipeline.
  always_comb begin
    pin_hist_next = {pin_hist_reg[3:0], reset_pin};
  end
  always_ff @(posedge core_clk) begin
    pin_hist_reg <= reset ? 5'h1f : pin_hist_next;
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  // A release of idle that is not caused by a reset source.
  sequence s_wake;
    $fell(idle_active) && !system_reset_req;
  endsequence
  sequence s_pulse;
    resume_branch || resume_next;
  endsequence

  a_osc_kept_on: assert property (main_osc_en)
    else $error("main oscillator enable dropped");
  a_idle_units_off: assert property (
    idle_active |-> (clk_en & STOP_MASK) == '0)
    else $error("a unit that must stop is clocked in idle");
  a_run_all_on: assert property (!idle_active |-> &clk_en)
    else $error("clock enable low outside idle");
  a_wake_one_way: assert property (
    s_wake |-> resume_branch ^ resume_next)
    else $error("idle release without exactly one resume pulse");
  a_ack_is_branch: assert property (wake_ack == resume_branch)
    else $error("acknowledge and branch disagree");
  a_pulse_at_release: assert property (
    s_pulse |-> $past(idle_active) && !idle_active ##1
    !(resume_branch || resume_next))
    else $error("resume pulse not tied to a one-cycle release");
  a_second_16bit_timer_needs_watch: assert property (
    idle_active && clk_en[EN_SECOND_16BIT_TIMER] |-> clk_en[EN_WATCH])
    else $error("second 16-bit timer runs without the watch timer");
  a_reset_forward: assert property (
    internal_reset_req |=> system_reset_req)
    else $error("internal reset not forwarded");
  a_wdt1_ignored: assert property (
    idle_active && first_watchdog_reset && !internal_reset_req &&
    !reset_pin && pin_hist_reg == 5'h00 |=> !system_reset_req)
    else $error("first watchdog reset honoured in idle");
endmodule

bind iwc_top iwc_props u_props (
  .core_clk, .reset, .reset_pin, .internal_reset_req,
  .first_watchdog_reset, .clk_en, .main_osc_en, .idle_active, .wake_ack,
  .resume_branch, .resume_next, .system_reset_req
);

// ---- tb/iwc_intc_model.sv ----
// Interrupt controller model: one maskable request that stays pending
// until the controller acknowledges it or the bench withdraws it.
// Assumes bench commands are one-cycle pulses on the core clock.
`timescale 1ns/1ns
module iwc_intc_model
  import iwc_pkg::*;
(
  // Clock and reset.
  input  wire logic              core_clk,
  input  wire logic              reset,
  // Bench commands.
  input  wire logic              raise,
  input  wire logic              withdraw,
  input  wire logic [PRIO_W-1:0] prio,
  // Controller side.
  input  wire logic              wake_ack,
  output logic                   maskable_req,
  output logic [PRIO_W-1:0]      req_prio
);
  logic              pend_reg;
  logic              pend_next;
  logic [PRIO_W-1:0] prio_reg;
  logic [PRIO_W-1:0] prio_next;

  // A wake without acknowledge leaves the request in place.
  always_comb begin
    pend_next = pend_reg;
    prio_next = prio_reg;
    if (raise) begin
      pend_next = 1'b1;
      prio_next = prio;
    end else if (wake_ack || withdraw) begin
      pend_next = 1'b0;
    end
  end
  always_ff @(posedge core_clk) begin
    pend_reg <= reset ? 1'b0 : pend_next;
    prio_reg <= reset ? 3'h0 : prio_next;
  end

  // With nothing pending the priority is meaningless, so show the inverse.
  assign maskable_req = pend_reg;
  assign req_prio     = pend_reg ? prio_reg : ~prio_reg;
endmodule

// ---- tb/testbench.sv ----
// Bench for the idle wake-up controller: AHB-Lite tasks and sequences of
// idle entries, wakes and resets. Assumes iwc_pkg and the model exist.
`timescale 1ns/1ns
module testbench;
  import iwc_pkg::*;
  // Stimulus, changed right after a rising edge.
  logic              core_clk = 1'b0;
  logic              reset = 1'b1;
  logic              hsel = 1'b0;
  logic              hwrite = 1'b0;
  logic [1:0]        htrans = 2'h0;
  logic [31:0]       haddr = 32'h0;
  logic [31:0]       hwdata = 32'h0;
  logic              nmi_pin = 1'b0;
  logic              wdt_nmi_req = 1'b0;
  logic              int_enable = 1'b1;
  logic              in_service = 1'b0;
  logic [PRIO_W-1:0] svc_prio = 3'h2;
  logic              reset_pin = 1'b0;
  logic              internal_reset_req = 1'b0;
  logic              first_watchdog_reset = 1'b0;
  logic              raise = 1'b0;
  logic              withdraw = 1'b0;
  logic [PRIO_W-1:0] prio = 3'h0;
  // Observed outputs.
  logic              hreadyout;
  logic              hresp;
  logic [31:0]       hrdata;
  logic [EN_W-1:0]   clk_en;
  logic              main_osc_en;
  logic              idle_active;
  logic              wake_ack;
  logic              resume_branch;
  logic              resume_next;
  logic              system_reset_req;
  logic              maskable_req;
  logic [PRIO_W-1:0] req_prio;
  int                errors = 0;
  int                cmp_count = 0;

  always #4 core_clk = ~core_clk;

  // Device under test and the interrupt controller beside it.
  iwc_top uut (
    .core_clk(core_clk), .reset(reset), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .nmi_pin(nmi_pin), .wdt_nmi_req(wdt_nmi_req),
    .maskable_req(maskable_req), .req_prio(req_prio),
    .int_enable(int_enable), .in_service(in_service), .svc_prio(svc_prio),
    .reset_pin(reset_pin), .internal_reset_req(internal_reset_req),
    .first_watchdog_reset(first_watchdog_reset), .clk_en(clk_en),
    .main_osc_en(main_osc_en), .idle_active(idle_active),
    .wake_ack(wake_ack), .resume_branch(resume_branch),
    .resume_next(resume_next), .system_reset_req(system_reset_req));
  iwc_intc_model u_intc (
    .core_clk(core_clk), .reset(reset), .raise(raise),
    .withdraw(withdraw), .prio(prio), .wake_ack(wake_ack),
    .maskable_req(maskable_req), .req_prio(req_prio));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("errors=%0d compares=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // One single transfer; the idle edge first avoids the old-value hazard.
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    @(posedge core_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h0, a};
    @(posedge core_clk);
    while (hreadyout !== 1'b1) @(posedge core_clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge core_clk);
    while (hreadyout !== 1'b1) @(posedge core_clk);
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, e);
    // Zero-wait slave: ready high and OKAY at the data-phase edge.
    chk({hresp, hreadyout}, 2'b01);
  endtask

  // Set the clock sources, enter idle and check the gated enables.
  task automatic nap(input logic [11:0] cfg, input logic [3:0] ctl,
                     input logic [EN_W-1:0] en);
    wr(OFS_CLKSRC, {20'h0, cfg});
    wr(OFS_CTRL, {28'h0, ctl});
    @(negedge core_clk);
    chk({idle_active, clk_en}, {1'b1, en});
    // Hand back at a rising edge so the next input change lands there.
    @(posedge core_clk);
  endtask
  task automatic req(input logic [PRIO_W-1:0] p);
    @(posedge core_clk);
    raise <= 1'b1;
    prio <= p;
    @(posedge core_clk);
    raise <= 1'b0;
  endtask
  task automatic drop;
    @(posedge core_clk);
    withdraw <= 1'b1;
    @(posedge core_clk);
    withdraw <= 1'b0;
  endtask
  // Wait for the release, then check pulses, enables and status.
  task automatic wake(input logic ack, input logic nxt, input logic [5:0] st);
    int n;
    n = 0;
    @(negedge core_clk);
    while (idle_active === 1'b1 && n < 40) begin
      @(negedge core_clk);
      n++;
    end
    chk({idle_active, wake_ack, resume_branch, resume_next, clk_en},
        {1'b0, ack, ack, nxt, {EN_W{1'b1}}});
    @(negedge core_clk);
    chk({wake_ack, resume_branch, resume_next}, 3'h0);
    rd(OFS_STATUS, {26'h0, st});
  endtask

  initial begin
    repeat (12) @(posedge core_clk);
    reset <= 1'b0;
    for (int i = 0; i < 5; i++) rd(8'(4 * i), 32'h0);
    wr(8'h10, 32'hffff_ffff);
    rd(8'h10, 32'h0);
    wr(OFS_MODE, 32'h1);
    wr(OFS_CTRL, 32'h1);
    @(negedge core_clk);
    chk(idle_active, 1'b0);
    wr(OFS_MODE, 32'h0);
    nap(12'h003, 4'h1, 17'h00108);
    req(3'h3);
    wake(1'b1, 1'b0, 6'h1c);
    in_service <= 1'b1;
    nap(12'hfb1, 4'h1, 17'h03d38);
    req(3'h5);
    wake(1'b0, 1'b1, 6'h24);
    chk(maskable_req, 1'b1);
    drop();
    nap(12'h044, 4'h1, 17'h00090);
    req(3'h2);
    wake(1'b0, 1'b1, 6'h24);
    drop();
    nap(12'h003, 4'h1, 17'h00108);
    req(3'h1);
    wake(1'b1, 1'b0, 6'h1c);
    in_service <= 1'b0;
    int_enable <= 1'b0;
    nap(12'h003, 4'h1, 17'h00108);
    req(3'h0);
    wake(1'b0, 1'b1, 6'h24);
    drop();
    nap(12'h003, 4'hd, 17'h00108);
    req(3'h0);
    wdt_nmi_req <= 1'b1;
    repeat (20) @(negedge core_clk);
    chk(idle_active, 1'b1);
    drop();
    wdt_nmi_req <= 1'b0;
    nmi_pin <= 1'b1;
    wake(1'b1, 1'b0, 6'h1a);
    nmi_pin <= 1'b0;
    repeat (6) @(posedge core_clk);
    nap(12'h003, 4'h3, 17'h00108);
    nmi_pin <= 1'b1;
    repeat (20) @(negedge core_clk);
    chk(idle_active, 1'b1);
    @(posedge core_clk);
    nmi_pin <= 1'b0;
    wdt_nmi_req <= 1'b1;
    wake(1'b1, 1'b0, 6'h1a);
    wdt_nmi_req <= 1'b0;
    nap(12'h003, 4'h1, 17'h00108);
    @(posedge core_clk);
    first_watchdog_reset <= 1'b1;
    @(posedge core_clk);
    first_watchdog_reset <= 1'b0;
    repeat (10) @(negedge core_clk);
    chk({idle_active, system_reset_req}, 2'b10);
    @(posedge core_clk);
    internal_reset_req <= 1'b1;
    @(posedge core_clk);
    internal_reset_req <= 1'b0;
    @(negedge core_clk);
    chk({idle_active, system_reset_req, resume_branch, resume_next},
        4'b0100);
    nap(12'h003, 4'h1, 17'h00108);
    reset_pin <= 1'b1;
    repeat (8) @(negedge core_clk);
    chk({idle_active, system_reset_req}, 2'b01);
    @(posedge core_clk);
    reset_pin <= 1'b0;
    repeat (8) @(posedge core_clk);
    first_watchdog_reset <= 1'b1;
    @(posedge core_clk);
    first_watchdog_reset <= 1'b0;
    @(negedge core_clk);
    chk(system_reset_req, 1'b1);
    tally_and_finish();
  end

  // A hang is cut short well beyond the few hundred cycles expected.
  initial begin
    #100000;
    errors++;
    $display("BAD t=%0t timeout", $time);
    tally_and_finish();
  end
endmodule
